// ### src/lpc_defines.svh
// offsets, field positions, reset values and timing counts of the sensor register bank
`ifndef LPC_DEFINES_SVH
`define LPC_DEFINES_SVH

// ----------------------------------------------------------------
// bus address and register offsets
// ----------------------------------------------------------------
`define LPC_I2C_ADDR 7'h44
`define LPC_REG_ID 8'h00
`define LPC_REG_PROX 8'h01
`define LPC_REG_SENSE 8'h02
`define LPC_REG_IRC 8'h03
`define LPC_REG_INT 8'h04

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LPC_PROX_EN_BIT 5
`define LPC_PROXIMITY_SLEEP_SELECT_HI 4
`define LPC_PROXIMITY_SLEEP_SELECT_LO 2
`define LPC_EMIT_CUR_HI 1
`define LPC_EMIT_CUR_LO 0
`define LPC_ALG_BIT 7
`define LPC_OFFS_HI 6
`define LPC_OFFS_LO 3
`define LPC_LEN_BIT 2
`define LPC_RANGE_HI 1
`define LPC_RANGE_LO 0
`define LPC_TRIM_HI 4
`define LPC_TRIM_LO 0
`define LPC_PFLAG_BIT 7
`define LPC_PPRST_HI 6
`define LPC_PPRST_LO 5
`define LPC_BOUT_BIT 4
`define LPC_LFLAG_BIT 3
`define LPC_LPRST_HI 2
`define LPC_LPRST_LO 1
`define LPC_COMB_BIT 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LPC_PROX_RST 8'h00
`define LPC_SENSE_RST 8'h00
`define LPC_IRC_RST 8'h00
`define LPC_INT_RST 8'h10
// identification code, arbitrary value
`define LPC_ID_CODE 5'h0A

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LPC_CLK_HZ 50000000
`define LPC_EMIT_US 200
`define LPC_SLEEP0_MS 800
`define LPC_SLEEP1_MS 200
`define LPC_SLEEP2_MS 100
`define LPC_EMIT_CYC (`LPC_EMIT_US * (`LPC_CLK_HZ / 1000000))
`define LPC_SLEEP0_CYC (`LPC_SLEEP0_MS * (`LPC_CLK_HZ / 1000))
`define LPC_SLEEP1_CYC (`LPC_SLEEP1_MS * (`LPC_CLK_HZ / 1000))
`define LPC_SLEEP2_CYC (`LPC_SLEEP2_MS * (`LPC_CLK_HZ / 1000))

`endif

// ### src/lpc_event.sv
// threshold compare, algorithm choice and persistence count for one sensing channel
`timescale 1ns/1ps
module lpc_event #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // conversion result and thresholds
  input wire logic done_i,
  input wire logic [W-1:0] data_i,
  input wire logic [W-1:0] tl_i,
  input wire logic [W-1:0] th_i,
  // setup
  input wire logic window_i,
  input wire logic [1:0] prst_i,
  // one-cycle event pulse
  output logic hit_o
);

  logic hyst_r, hyst_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic hit_r, hit_nxt;
  logic cond;
  logic [3:0] need;

  always_comb begin
    hyst_nxt = hyst_r;
    cnt_nxt = cnt_r;
    hit_nxt = 1'b0;
    // RQ14: window or hysteresis
    if (window_i) begin
      cond = (data_i < tl_i) || (data_i > th_i);
    end else begin
      cond = (data_i > th_i) || (hyst_r && (data_i >= tl_i));
    end
    // RQ5: 1, 2, 4 or 8 in a row
    need = 4'h1 << prst_i;
    if (done_i) begin
      if (!window_i) begin
        hyst_nxt = cond;
      end
      if (cond) begin
        // saturate so a long run fires only once
        cnt_nxt = (cnt_r == 4'h8) ? cnt_r : cnt_r + 4'h1;
        hit_nxt = ((cnt_r + 4'h1) == need);
      end else begin
        cnt_nxt = 4'h0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hyst_r <= 1'b0;
      cnt_r <= 4'h0;
      hit_r <= 1'b0;
    end else begin
      hyst_r <= hyst_nxt;
      cnt_r <= cnt_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign hit_o = hit_r;

endmodule

// ### src/lpc_pkg.sv
// types of the sensor register bank
package lpc_pkg;

  // ----------------------------------------------------------------
  // serial slave states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    LPC_S_IDLE = 5'b00001,
    LPC_S_RX = 5'b00010,
    LPC_S_ACK = 5'b00100,
    LPC_S_TX = 5'b01000,
    LPC_S_MACK = 5'b10000
  } lpc_i2c_st_t;

  // ----------------------------------------------------------------
  // emitter sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LPC_E_OFF = 3'b001,
    LPC_E_PULSE = 3'b010,
    LPC_E_SLEEP = 3'b100
  } lpc_emit_st_t;

endpackage

// ### src/lpc_regs.sv
// serial-bus register bank, emitter sequencer and interrupt pin of the light/proximity sensor
`timescale 1ns/1ps
`include "lpc_defines.svh"

// What this block does
// RQ1: sleep select sets 800/200/100 ms interval
// RQ2: sensing bit 2 enables light conversions
// RQ3: range bits pick 62.5 to 2000 lux
// RQ4: five-bit IR trim, upper bits reserved
// RQ5: proximity persistence 1, 2, 4, 8 events
// RQ6: light persistence 1, 2, 4, 8 events
// RQ7: bit 7 flags pending proximity event
// RQ8: bit 3 flags pending light event
// RQ9: brown-out flag bit 4, resets to one
// RQ10: bit 0 combines events as AND/OR
// RQ11: emitter pulses 200 us per conversion
// RQ12: current select; emitter released when idle
// RQ13: brown-out no interrupt; host writes zero
// RQ14: algorithm bit picks window or hysteresis
// RQ15: proximity offset stored and subtracted from result
module lpc_regs
  import lpc_pkg::*;
#(
  parameter int unsigned EMIT_CYC = `LPC_EMIT_CYC,
  parameter int unsigned SLEEP0_CYC = `LPC_SLEEP0_CYC,
  parameter int unsigned SLEEP1_CYC = `LPC_SLEEP1_CYC,
  parameter int unsigned SLEEP2_CYC = `LPC_SLEEP2_CYC
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  // serial bus
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N_O,
  // emitter
  output logic EMIT_OE_N_O,
  output logic [1:0] EMIT_CURRENT_O,
  // light channel setup
  output logic LIGHT_EN_O,
  output logic [1:0] LIGHT_RANGE_O,
  output logic [4:0] LIGHT_IR_TRIM_O,
  // proximity conversion results
  input wire logic PROX_DONE_I,
  input wire logic [7:0] PROX_DATA_I,
  input wire logic [7:0] PROX_TL_I,
  input wire logic [7:0] PROX_TH_I,
  // light conversion results
  input wire logic LIGHT_DONE_I,
  input wire logic [11:0] LIGHT_DATA_I,
  input wire logic [11:0] LIGHT_TL_I,
  input wire logic [11:0] LIGHT_TH_I,
  // supply monitor and interrupt pin
  input wire logic BROWNOUT_I,
  output logic INT_N_O
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic scl_q_r, sda_q_r, scl_p_r, sda_p_r;
  lpc_i2c_st_t st_r, st_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic full_r, full_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [1:0] idx_r, idx_nxt;
  logic rd_r, rd_nxt;
  logic mack_r, mack_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic sda_oe_n_r, sda_oe_n_nxt;
  logic [5:0] prox_r, prox_nxt;
  logic [7:0] sense_r, sense_nxt;
  logic [4:0] irc_r, irc_nxt;
  logic pflag_r, pflag_nxt;
  logic lflag_r, lflag_nxt;
  logic bout_r, bout_nxt;
  logic [1:0] pprst_r, pprst_nxt;
  logic [1:0] lprst_r, lprst_nxt;
  logic comb_r, comb_nxt;
  logic int_n_r, int_n_nxt;
  lpc_emit_st_t est_r, est_nxt;
  logic [31:0] ecnt_r, ecnt_nxt;
  logic emit_oe_n_r, emit_oe_n_nxt;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic p_hit, l_hit;
  logic [7:0] prox_corr;
  logic [3:0] offs;
  logic [31:0] sleep_cyc;
  logic [7:0] rbyte;

  // ----------------------------------------------------------------
  // bus line edges
  // ----------------------------------------------------------------
  assign scl_rise = scl_q_r & ~scl_p_r;
  assign scl_fall = ~scl_q_r & scl_p_r;
  assign bus_start = scl_q_r & scl_p_r & sda_p_r & ~sda_q_r;
  assign bus_stop = scl_q_r & scl_p_r & ~sda_p_r & sda_q_r;

  // ----------------------------------------------------------------
  // event channels
  // ----------------------------------------------------------------
  assign offs = sense_r[`LPC_OFFS_HI:`LPC_OFFS_LO];
  // RQ15: offset removed, floored at zero
  assign prox_corr = (PROX_DATA_I > {4'h0, offs}) ? PROX_DATA_I - {4'h0, offs} : 8'h00;

  lpc_event #(.W(8)) u_prox_evt (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .done_i(PROX_DONE_I),
    .data_i(prox_corr),
    .tl_i(PROX_TL_I),
    .th_i(PROX_TH_I),
    .window_i(sense_r[`LPC_ALG_BIT]),
    .prst_i(pprst_r),
    .hit_o(p_hit)
  );

  // RQ6: light channel persistence
  lpc_event #(.W(12)) u_light_evt (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .done_i(LIGHT_DONE_I),
    .data_i(LIGHT_DATA_I),
    .tl_i(LIGHT_TL_I),
    .th_i(LIGHT_TH_I),
    .window_i(sense_r[`LPC_ALG_BIT]),
    .prst_i(lprst_r),
    .hit_o(l_hit)
  );

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    case (ptr_r)
      `LPC_REG_ID: rbyte = {`LPC_ID_CODE, 3'h0};
      `LPC_REG_PROX: rbyte = {2'h0, prox_r};
      `LPC_REG_SENSE: rbyte = sense_r;
      // RQ4: reserved bits read zero
      `LPC_REG_IRC: rbyte = {3'h0, irc_r};
      // RQ7: flags shown as stored
      `LPC_REG_INT: rbyte = {pflag_r, pprst_r, bout_r, lflag_r, lprst_r, comb_r};
      default: rbyte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // serial slave and register file
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    full_nxt = full_r;
    sh_nxt = sh_r;
    idx_nxt = idx_r;
    rd_nxt = rd_r;
    mack_nxt = mack_r;
    ptr_nxt = ptr_r;
    sda_oe_n_nxt = sda_oe_n_r;
    prox_nxt = prox_r;
    sense_nxt = sense_r;
    irc_nxt = irc_r;
    pflag_nxt = pflag_r;
    lflag_nxt = lflag_r;
    bout_nxt = bout_r;
    pprst_nxt = pprst_r;
    lprst_nxt = lprst_r;
    comb_nxt = comb_r;
    if (bus_start) begin
      st_nxt = LPC_S_RX;
      bit_nxt = 3'h0;
      full_nxt = 1'b0;
      idx_nxt = 2'h0;
      sda_oe_n_nxt = 1'b1;
    end else if (bus_stop) begin
      st_nxt = LPC_S_IDLE;
      sda_oe_n_nxt = 1'b1;
    end else begin
      case (st_r)
        LPC_S_IDLE: begin
          sda_oe_n_nxt = 1'b1;
        end
        LPC_S_RX: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_q_r};
            bit_nxt = bit_r + 3'h1;
            full_nxt = (bit_r == 3'h7);
          end else if (scl_fall && full_r) begin
            full_nxt = 1'b0;
            st_nxt = LPC_S_ACK;
            sda_oe_n_nxt = 1'b0;
            if (idx_r == 2'h0) begin
              rd_nxt = sh_r[0];
              idx_nxt = 2'h1;
              if (sh_r[7:1] != `LPC_I2C_ADDR) begin
                st_nxt = LPC_S_IDLE;
                sda_oe_n_nxt = 1'b1;
              end
            end else if (idx_r == 2'h1) begin
              ptr_nxt = sh_r;
              idx_nxt = 2'h2;
            end else begin
              ptr_nxt = ptr_r + 8'h01;
              case (ptr_r)
                `LPC_REG_PROX: prox_nxt = sh_r[5:0];
                // RQ2: enable bit, range and offset stored
                `LPC_REG_SENSE: sense_nxt = sh_r;
                `LPC_REG_IRC: irc_nxt = sh_r[`LPC_TRIM_HI:`LPC_TRIM_LO];
                `LPC_REG_INT: begin
                  pprst_nxt = sh_r[`LPC_PPRST_HI:`LPC_PPRST_LO];
                  lprst_nxt = sh_r[`LPC_LPRST_HI:`LPC_LPRST_LO];
                  comb_nxt = sh_r[`LPC_COMB_BIT];
                  // RQ13: host writes zero to clear
                  if (!sh_r[`LPC_BOUT_BIT]) begin
                    bout_nxt = 1'b0;
                  end
                end
                default: begin
                end
              endcase
            end
          end
        end
        LPC_S_ACK: begin
          if (scl_fall) begin
            bit_nxt = 3'h0;
            if (rd_r) begin
              st_nxt = LPC_S_TX;
              sh_nxt = rbyte;
              sda_oe_n_nxt = rbyte[7];
              ptr_nxt = ptr_r + 8'h01;
              // reading status clears event flags
              if (ptr_r == `LPC_REG_INT) begin
                pflag_nxt = 1'b0;
                lflag_nxt = 1'b0;
              end
            end else begin
              st_nxt = LPC_S_RX;
              sda_oe_n_nxt = 1'b1;
            end
          end
        end
        LPC_S_TX: begin
          if (scl_fall) begin
            bit_nxt = bit_r + 3'h1;
            if (bit_r == 3'h7) begin
              st_nxt = LPC_S_MACK;
              sda_oe_n_nxt = 1'b1;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              sda_oe_n_nxt = sh_r[6];
            end
          end
        end
        LPC_S_MACK: begin
          if (scl_rise) begin
            mack_nxt = ~sda_q_r;
          end else if (scl_fall) begin
            if (mack_r) begin
              st_nxt = LPC_S_TX;
              bit_nxt = 3'h0;
              sh_nxt = rbyte;
              sda_oe_n_nxt = rbyte[7];
              ptr_nxt = ptr_r + 8'h01;
              if (ptr_r == `LPC_REG_INT) begin
                pflag_nxt = 1'b0;
                lflag_nxt = 1'b0;
              end
            end else begin
              st_nxt = LPC_S_IDLE;
            end
          end
        end
        default: begin
          st_nxt = LPC_S_IDLE;
          sda_oe_n_nxt = 1'b1;
        end
      endcase
    end
    // RQ7: proximity event sets, wins over clear
    if (p_hit) begin
      pflag_nxt = 1'b1;
    end
    // RQ8: light event sets, wins over clear
    if (l_hit) begin
      lflag_nxt = 1'b1;
    end
    // RQ9: brown-out sets, wins over clear
    if (BROWNOUT_I) begin
      bout_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
      st_r <= LPC_S_IDLE;
      bit_r <= 3'h0;
      full_r <= 1'b0;
      sh_r <= 8'h00;
      idx_r <= 2'h0;
      rd_r <= 1'b0;
      mack_r <= 1'b0;
      ptr_r <= 8'h00;
      sda_oe_n_r <= 1'b1;
      prox_r <= 6'(`LPC_PROX_RST);
      sense_r <= `LPC_SENSE_RST;
      irc_r <= 5'(`LPC_IRC_RST);
      pflag_r <= 1'b0;
      lflag_r <= 1'b0;
      // RQ9: power-on value one
      bout_r <= 1'b1;
      pprst_r <= 2'h0;
      lprst_r <= 2'h0;
      comb_r <= 1'b0;
    end else begin
      scl_q_r <= SCL_I;
      sda_q_r <= SDA_I;
      scl_p_r <= scl_q_r;
      sda_p_r <= sda_q_r;
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      full_r <= full_nxt;
      sh_r <= sh_nxt;
      idx_r <= idx_nxt;
      rd_r <= rd_nxt;
      mack_r <= mack_nxt;
      ptr_r <= ptr_nxt;
      sda_oe_n_r <= sda_oe_n_nxt;
      prox_r <= prox_nxt;
      sense_r <= sense_nxt;
      irc_r <= irc_nxt;
      pflag_r <= pflag_nxt;
      lflag_r <= lflag_nxt;
      bout_r <= bout_nxt;
      pprst_r <= pprst_nxt;
      lprst_r <= lprst_nxt;
      comb_r <= comb_nxt;
    end
  end

  // ----------------------------------------------------------------
  // emitter sequencer
  // ----------------------------------------------------------------
  // RQ1: interval from sleep select
  always_comb begin
    case (prox_r[`LPC_PROXIMITY_SLEEP_SELECT_HI:`LPC_PROXIMITY_SLEEP_SELECT_LO])
      3'h0: sleep_cyc = SLEEP0_CYC;
      3'h1: sleep_cyc = SLEEP1_CYC;
      // undefined codes fall back to the shortest interval
      default: sleep_cyc = SLEEP2_CYC;
    endcase
  end

  always_comb begin
    est_nxt = est_r;
    ecnt_nxt = ecnt_r;
    emit_oe_n_nxt = 1'b1;
    case (est_r)
      LPC_E_OFF: begin
        ecnt_nxt = 32'h0000_0000;
        if (prox_r[`LPC_PROX_EN_BIT]) begin
          est_nxt = LPC_E_PULSE;
          emit_oe_n_nxt = 1'b0;
        end
      end
      // RQ11: pulse for the emitter time
      LPC_E_PULSE: begin
        emit_oe_n_nxt = 1'b0;
        ecnt_nxt = ecnt_r + 32'h0000_0001;
        if (ecnt_r == EMIT_CYC - 1) begin
          est_nxt = LPC_E_SLEEP;
          ecnt_nxt = 32'h0000_0000;
          emit_oe_n_nxt = 1'b1;
        end
      end
      LPC_E_SLEEP: begin
        ecnt_nxt = ecnt_r + 32'h0000_0001;
        if (ecnt_r >= sleep_cyc - 1) begin
          est_nxt = LPC_E_PULSE;
          ecnt_nxt = 32'h0000_0000;
          emit_oe_n_nxt = 1'b0;
        end
      end
      default: begin
        est_nxt = LPC_E_OFF;
      end
    endcase
    // RQ12: released whenever not pulsing
    if (!prox_r[`LPC_PROX_EN_BIT]) begin
      est_nxt = LPC_E_OFF;
      ecnt_nxt = 32'h0000_0000;
      emit_oe_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      est_r <= LPC_E_OFF;
      ecnt_r <= 32'h0000_0000;
      emit_oe_n_r <= 1'b1;
    end else begin
      est_r <= est_nxt;
      ecnt_r <= ecnt_nxt;
      emit_oe_n_r <= emit_oe_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // interrupt pin
  // ----------------------------------------------------------------
  // RQ10: and/or combine; RQ13: brown-out left out
  always_comb begin
    int_n_nxt = ~(comb_r ? (pflag_r & lflag_r) : (pflag_r | lflag_r));
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      int_n_r <= 1'b1;
    end else begin
      int_n_r <= int_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign SDA_O = 1'b0;
  assign SDA_OE_N_O = sda_oe_n_r;
  assign EMIT_OE_N_O = emit_oe_n_r;
  // RQ12: drive current straight from setup
  assign EMIT_CURRENT_O = prox_r[`LPC_EMIT_CUR_HI:`LPC_EMIT_CUR_LO];
  assign LIGHT_EN_O = sense_r[`LPC_LEN_BIT];
  // RQ3: range select to converter
  assign LIGHT_RANGE_O = sense_r[`LPC_RANGE_HI:`LPC_RANGE_LO];
  assign LIGHT_IR_TRIM_O = irc_r;
  assign INT_N_O = int_n_r;

endmodule

// ### testbench/lpc_host_model.sv
// serial bus host model driving the register bank
`timescale 1ns/1ps
`include "lpc_defines.svh"
module lpc_host_model (
  // clock and device pull-down
  input wire logic clk_i,
  input wire logic sda_oe_n_i,
  // bus wires
  output logic scl_o,
  output logic sda_o
);
  logic scl_r = 1'b1;
  logic drv_r = 1'b1;
  // pulled up: low if either party pulls
  assign sda_o = drv_r & sda_oe_n_i;
  assign scl_o = scl_r;
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // eight clocks each phase, data moves mid-low
  task automatic bitx(input logic b, output logic r);
    drv_r = b;
    wt(4);
    scl_r = 1'b1;
    wt(4);
    r = sda_o;
    wt(4);
    scl_r = 1'b0;
    wt(4);
  endtask
  task automatic start();
    drv_r = 1'b1;
    wt(4);
    scl_r = 1'b1;
    wt(4);
    drv_r = 1'b0;
    wt(8);
    scl_r = 1'b0;
    wt(4);
  endtask
  task automatic stop();
    drv_r = 1'b0;
    wt(4);
    scl_r = 1'b1;
    wt(4);
    drv_r = 1'b1;
    wt(8);
  endtask
  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic rb(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(1'b1, r);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic a, b, c;
    start();
    wb({`LPC_I2C_ADDR, 1'b0}, a);
    wb(p, b);
    wb(d, c);
    stop();
    ok = a & b & c;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic a, b, c;
    start();
    wb({`LPC_I2C_ADDR, 1'b0}, a);
    wb(p, b);
    start();
    wb({`LPC_I2C_ADDR, 1'b1}, c);
    rb(d);
    stop();
    ok = a & b & c;
  endtask
  task automatic probe(input logic [6:0] adr, output logic ok);
    start();
    wb({adr, 1'b0}, ok);
    stop();
  endtask
endmodule

// ### testbench/lpc_regs_checker.sv
// port assertions of the sensor register bank
`timescale 1ns/1ps
module lpc_regs_checker #(
  parameter int unsigned EMIT_CYC = 20,
  parameter int unsigned SLEEP2_CYC = 20
) (
  // clock, reset, bus
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic SCL_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_N_O,
  // sensing side
  input wire logic EMIT_OE_N_O,
  input wire logic LIGHT_EN_O,
  input wire logic [1:0] LIGHT_RANGE_O,
  input wire logic PROX_DONE_I,
  input wire logic LIGHT_DONE_I,
  input wire logic BROWNOUT_I,
  input wire logic INT_N_O
);
  // ----
  // pulse, gap and event history
  // ----
  logic [15:0] lo_r, lo_nxt, hi_r, hi_nxt;
  logic seen_r, seen_nxt;
  logic [4:0] dn_r, dn_nxt;
  always_comb begin
    lo_nxt = EMIT_OE_N_O ? 16'h0000 : lo_r + 16'h0001;
    hi_nxt = EMIT_OE_N_O ? hi_r + 16'h0001 : 16'h0000;
    // first gap after reset is not a full sleep
    seen_nxt = seen_r | (EMIT_OE_N_O & (lo_r != 16'h0000));
    dn_nxt = {dn_r[3:0], PROX_DONE_I | LIGHT_DONE_I};
  end
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      lo_r <= 16'h0000;
      hi_r <= 16'h0000;
      seen_r <= 1'b0;
      dn_r <= 5'h00;
    end else begin
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
      seen_r <= seen_nxt;
      dn_r <= dn_nxt;
    end
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  // ----
  // assertions
  // ----
  chk_sda_open: assert property (SDA_O == 1'b0)
    else $error("data pin value not low");
  chk_emit_width: assert property ($rose(EMIT_OE_N_O) |-> lo_r == EMIT_CYC)
    else $error("emitter pulse length wrong");
  chk_emit_gap: assert property ($fell(EMIT_OE_N_O) && seen_r |-> hi_r >= SLEEP2_CYC)
    else $error("emitter sleep too short");
  chk_int_cause: assert property ($fell(INT_N_O) |-> dn_r[2] || dn_r[3])
    else $error("interrupt without conversion event");
  chk_bout_quiet: assert property (
    $rose(BROWNOUT_I) && INT_N_O && dn_r == 5'h00 && !PROX_DONE_I && !LIGHT_DONE_I
    |=> INT_N_O [*3])
    else $error("brown-out drove interrupt");
  chk_ack_low: assert property ($changed(SDA_OE_N_O) |-> !SCL_I)
    else $error("data pin changed with clock high");
  chk_cfg_commit: assert property ($changed({LIGHT_EN_O, LIGHT_RANGE_O}) |-> !SCL_I)
    else $error("light setup changed outside commit");
  chk_int_clear: assert property ($rose(INT_N_O) |-> !SCL_I)
    else $error("interrupt released outside read");
  chk_reset_vals: assert property ($fell(RESET_I) |-> SDA_OE_N_O && EMIT_OE_N_O
    && INT_N_O && !LIGHT_EN_O && LIGHT_RANGE_O == 2'h0)
    else $error("outputs not at reset values");
  cover property ($fell(INT_N_O));
  cover property ($rose(EMIT_OE_N_O) && seen_r);
  cover property ($fell(SDA_OE_N_O));
endmodule

bind lpc_regs lpc_regs_checker #(
  .EMIT_CYC(EMIT_CYC),
  .SLEEP2_CYC(SLEEP2_CYC)
) u_chk (
  .CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .SCL_I(SCL_I), .SDA_O(SDA_O),
  .SDA_OE_N_O(SDA_OE_N_O), .EMIT_OE_N_O(EMIT_OE_N_O), .LIGHT_EN_O(LIGHT_EN_O),
  .LIGHT_RANGE_O(LIGHT_RANGE_O), .PROX_DONE_I(PROX_DONE_I), .LIGHT_DONE_I(LIGHT_DONE_I),
  .BROWNOUT_I(BROWNOUT_I), .INT_N_O(INT_N_O)
);

// ### testbench/lpc_regs_tb.sv
// self-checking bench of the sensor register bank
`timescale 1ns/1ps
`include "lpc_defines.svh"
module lpc_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bout = 1'b0;
  logic pdone = 1'b0;
  logic ldone = 1'b0;
  logic [7:0] pdata = 8'h00;
  logic [11:0] ldata = 12'h000;
  logic [7:0] ptl = 8'h10;
  logic [7:0] pth = 8'h80;
  logic [11:0] ltl = 12'h010;
  logic [11:0] lth = 12'h800;
  logic scl, sda, sda_oe_n, emit_n, len, int_n, ok;
  logic [1:0] cur, rng;
  logic [4:0] trim;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int lo, hi;
  logic [7:0] rv [6] = '{{`LPC_ID_CODE, 3'b000}, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
  // longest sleep last: the final disable then lands in a gap
  logic [2:0] sc [4] = '{3'h7, 3'h2, 3'h1, 3'h0};
  int ex [4] = '{20, 20, 40, 80};
  always #10 clk = ~clk;
  lpc_regs #(
    .EMIT_CYC(20), .SLEEP0_CYC(80), .SLEEP1_CYC(40), .SLEEP2_CYC(20)
  ) DUT (
    .CLOCK_I(clk), .RESET_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
    .SDA_OE_N_O(sda_oe_n), .EMIT_OE_N_O(emit_n), .EMIT_CURRENT_O(cur),
    .LIGHT_EN_O(len), .LIGHT_RANGE_O(rng), .LIGHT_IR_TRIM_O(trim),
    .PROX_DONE_I(pdone), .PROX_DATA_I(pdata), .PROX_TL_I(ptl), .PROX_TH_I(pth),
    .LIGHT_DONE_I(ldone), .LIGHT_DATA_I(ldata), .LIGHT_TL_I(ltl),
    .LIGHT_TH_I(lth), .BROWNOUT_I(bout), .INT_N_O(int_n)
  );
  lpc_host_model HOST (.clk_i(clk), .sda_oe_n_i(sda_oe_n), .scl_o(scl), .sda_o(sda));
  // ----
  // shared tasks
  // ----
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    HOST.rd(p, d, ok);
    chk("ack", 1'b1, ok);
    chk("register", e, d);
  endtask
  task automatic wrc(input logic [7:0] p, input logic [7:0] d);
    HOST.wr(p, d, ok);
    chk("ack", 1'b1, ok);
  endtask
  // light result scaled up so one value suits both channels
  task automatic ev(input logic ch, input logic [7:0] v);
    pdata = v;
    ldata = {v, 4'h0};
    pdone = ~ch;
    ldone = ch;
    @(negedge clk);
    pdone = 1'b0;
    ldone = 1'b0;
    repeat (5) @(negedge clk);
  endtask
  task automatic meas();
    lo = 0;
    hi = 0;
    while (emit_n !== 1'b0) @(negedge clk);
    while (emit_n === 1'b0) @(negedge clk);
    while (emit_n === 1'b1) begin
      hi++;
      @(negedge clk);
    end
    while (emit_n === 1'b0) begin
      lo++;
      @(negedge clk);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard, well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      $display("MISMATCH cycles expected %0d seen %0d", 59999, cyc);
      summarize();
    end
  end
  // ----
  // test sequence
  // ----
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int a = 0; a < 6; a++) rdc(a[7:0], rv[a]);
    wrc(8'h00, 8'hFF);
    rdc(8'h00, rv[0]);
    HOST.probe(7'h45, ok);
    chk("ack", 1'b0, ok);
    $display("test reset and map done");
    for (int r = 0; r < 4; r++) begin
      wrc(8'h02, {1'b0, 4'(r * 5), r[0], r[1:0]});
      rdc(8'h02, {1'b0, 4'(r * 5), r[0], r[1:0]});
      chk("light_en", r[0], len);
      chk("range", r[1:0], rng);
    end
    wrc(8'h03, 8'hFF);
    rdc(8'h03, 8'h1F);
    chk("trim", 5'h1F, trim);
    $display("test setup fields done");
    wrc(8'h04, 8'h00);
    rdc(8'h04, 8'h00);
    wrc(8'h04, 8'h10);
    rdc(8'h04, 8'h00);
    bout = 1'b1;
    @(negedge clk);
    bout = 1'b0;
    repeat (4) @(negedge clk);
    chk("int_n", 1'b1, int_n);
    rdc(8'h04, 8'h10);
    wrc(8'h04, 8'h00);
    $display("test brown-out done");
    wrc(8'h02, 8'h04);
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 4; c++) begin
        wrc(8'h04, ch ? {5'h00, c[1:0], 1'b0} : {1'b0, c[1:0], 5'h00});
        repeat ((1 << c) - 1) ev(ch[0], 8'hC0);
        chk("int_n", 1'b1, int_n);
        ev(ch[0], 8'hC0);
        chk("int_n", 1'b0, int_n);
        rdc(8'h04, ch ? {4'h0, 1'b1, c[1:0], 1'b0} : {1'b1, c[1:0], 5'h00});
        chk("int_n", 1'b1, int_n);
        ev(ch[0], 8'h00);
      end
    end
    $display("test persistence done");
    wrc(8'h04, 8'h01);
    ev(1'b0, 8'hC0);
    chk("int_n", 1'b1, int_n);
    ev(1'b1, 8'hC0);
    chk("int_n", 1'b0, int_n);
    rdc(8'h04, 8'h89);
    ev(1'b0, 8'h00);
    ev(1'b1, 8'h00);
    wrc(8'h04, 8'h00);
    wrc(8'h02, 8'h84);
    ev(1'b0, 8'h05);
    chk("int_n", 1'b0, int_n);
    rdc(8'h04, 8'h80);
    ev(1'b0, 8'h40);
    wrc(8'h02, 8'h04);
    ev(1'b0, 8'h05);
    chk("int_n", 1'b1, int_n);
    wrc(8'h02, 8'h7C);
    ev(1'b0, 8'h85);
    chk("int_n", 1'b1, int_n);
    wrc(8'h02, 8'h04);
    ev(1'b0, 8'h85);
    chk("int_n", 1'b0, int_n);
    rdc(8'h04, 8'h80);
    // hysteresis holds the second reading below the raised high mark
    wrc(8'h04, 8'h20);
    ev(1'b0, 8'h00);
    ev(1'b0, 8'h85);
    pth = 8'hF0;
    ev(1'b0, 8'hC0);
    rdc(8'h04, 8'hA0);
    $display("test combine and algorithm done");
    chk("emit_n", 1'b1, emit_n);
    for (int s = 0; s < 4; s++) begin
      wrc(8'h01, {3'b001, sc[s], s[1:0]});
      chk("current", s[1:0], cur);
      meas();
      chk("pulse", 12'd20, lo[11:0]);
      chk("sleep", ex[s][11:0], hi[11:0]);
    end
    wrc(8'h01, 8'h00);
    repeat (40) @(negedge clk);
    chk("emit_n", 1'b1, emit_n);
    $display("test emitter done");
    summarize();
  end
endmodule
